// ==== inc/stp_pkg.sv ====
package stp_pkg;
    localparam logic [7:0] ADDR_MOVE = 8'h00;
    localparam logic [7:0] ADDR_MOVE_CFG = 8'h04;
    localparam logic [7:0] ADDR_OVL = 8'h08;
    localparam logic [7:0] ADDR_TEXT = 8'h0c;
    localparam logic [7:0] ADDR_VID = 8'h10;
    localparam logic [7:0] ADDR_BLK = 8'h14;
    localparam logic [7:0] ADDR_CMD = 8'h18;
    localparam logic [7:0] ADDR_GRP_SEL = 8'h1c;
    localparam logic [7:0] ADDR_GRP_VID = 8'h20;
    localparam logic [7:0] ADDR_GRP_HOFS = 8'h24;
    localparam logic [7:0] ADDR_GRP_VOFS = 8'h28;
    localparam logic [7:0] ADDR_GRP_HSTEP = 8'h2c;
    localparam logic [7:0] ADDR_GRP_VSTEP = 8'h30;
    localparam logic [7:0] ADDR_STATUS = 8'h34;

    localparam int DISP_W = 9;
    localparam int HOFS_W = 20;
    localparam int LINE_W = 16;
    localparam int FRAC_W = 8;
    localparam int POS_W = 12;
    localparam int TEXT_LEN = 16;

    localparam logic signed [DISP_W-1:0] DISP_MAX = 9'sd252;
    localparam logic [4:0] PERIOD_MIN = 5'h01;
    localparam logic [4:0] PERIOD_MAX = 5'h10;
    localparam logic [6:0] PCT_MAX = 7'h64;
    localparam logic [1:0] GRP_SIGNAL = 2'h1;
    localparam logic [1:0] GRP_BLACK = 2'h2;

    // Reset values
    localparam logic [4:0] RST_PERIOD = 5'h01;
    localparam logic [2:0] RST_COMP_EN = 3'h7;
    localparam logic [15:0] RST_LFSR = 16'hace1;

    localparam int CLK_MHZ = 100;
    localparam int OVERLAY_A_SHORT_MS = 500;
    localparam int OVERLAY_A_LONG_MS = 1000;
    localparam int OVERLAY_A_SHORT_HALF_CYC = OVERLAY_A_SHORT_MS * CLK_MHZ * 1000 / 2;
    localparam int OVERLAY_A_LONG_HALF_CYC = OVERLAY_A_LONG_MS * CLK_MHZ * 1000 / 2;

    typedef enum logic [1:0] {
        FMT_525_RATE143 = 2'h0,
        FMT_525_RATE270 = 2'h1,
        FMT_625_RATE270 = 2'h2
    } stp_fmt_t;

    typedef enum logic [1:0] {
        SIG_BLACK = 2'h0,
        FLAT_FIELD_40 = 2'h1,
        FLAT_FIELD_50 = 2'h2,
        FLAT_FIELD_100 = 2'h3
    } stp_black_sig_t;

    function automatic logic signed [DISP_W-1:0] clamp_disp(input logic [31:0] w);
        logic signed [31:0] s;
        s = $signed(w);
        if (s > 32'sd252) begin
            clamp_disp = DISP_MAX;
        end else if (s < -32'sd252) begin
            clamp_disp = -DISP_MAX;
        end else begin
            clamp_disp = s[DISP_W-1:0];
        end
    endfunction

    function automatic logic [6:0] clamp_pct(input logic [7:0] v);
        clamp_pct = (v > {1'b0, PCT_MAX}) ? PCT_MAX : v[6:0];
    endfunction
endpackage

// ==== logic/stp_ofs_norm.sv ====
`timescale 1ns/1ns
`default_nettype none
module stp_ofs_norm
    import stp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [HOFS_W-1:0] h_req,
    input wire logic [LINE_W-1:0] v_req,
    input wire logic [LINE_W-1:0] line_len,
    output logic [HOFS_W-1:0] h_out,
    output logic [LINE_W-1:0] v_out,
    output logic busy
);
    typedef enum logic {NRM_IDLE, NRM_RUN} stp_nrm_t;
    stp_nrm_t state_q;
    logic [HOFS_W-1:0] h_q, h_last_q;
    logic [LINE_W-1:0] v_q, v_last_q, len_last_q;
    logic changed;

    assign changed = (h_req != h_last_q) || (v_req != v_last_q) || (line_len != len_last_q);
    assign busy = (state_q == NRM_RUN);

    // Iterative subtraction avoids a divider; stays busy for h_req/line_len + 1 cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= NRM_IDLE;
            h_q <= '0;
            v_q <= '0;
            h_last_q <= '0;
            v_last_q <= '0;
            len_last_q <= '0;
            h_out <= '0;
            v_out <= '0;
        end else begin
            case (state_q)
                NRM_IDLE: begin
                    if (changed) begin
                        h_last_q <= h_req;
                        v_last_q <= v_req;
                        len_last_q <= line_len;
                        h_q <= h_req;
                        v_q <= v_req;
                        state_q <= NRM_RUN;
                    end
                end
                NRM_RUN: begin
                    if (line_len != '0 && h_q >= HOFS_W'(line_len)) begin
                        h_q <= h_q - HOFS_W'(line_len);
                        v_q <= v_q + 16'h0001;
                    end else begin
                        h_out <= h_q;
                        v_out <= v_q;
                        state_q <= NRM_IDLE;
                    end
                end
                default: state_q <= NRM_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== logic/stp_scroll.sv ====
`timescale 1ns/1ns
`default_nettype none
module stp_scroll
    import stp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic field_start,
    input wire logic signed [DISP_W-1:0] h_disp,
    input wire logic signed [DISP_W-1:0] v_disp,
    input wire logic [4:0] period,
    input wire logic random_en,
    output logic [POS_W-1:0] h_pos,
    output logic [POS_W-1:0] v_pos
);
    logic [4:0] fld_cnt_q;
    logic [15:0] lfsr_q;
    logic signed [DISP_W-1:0] rnd_h, rnd_v;

    // Random steps keep horizontal 4-aligned in -128..124 and vertical in -64..63; both stay inside the legal range
    assign rnd_h = {lfsr_q[7], lfsr_q[7:2], 2'b00};
    assign rnd_v = $signed({lfsr_q[15], lfsr_q[15:8]}) >>> 1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr_q <= RST_LFSR;
        end else if (field_start) begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fld_cnt_q <= 5'h01;
            h_pos <= '0;
            v_pos <= '0;
        end else if (field_start) begin
            if (fld_cnt_q >= period) begin
                fld_cnt_q <= 5'h01;
                if (random_en) begin
                    h_pos <= h_pos + POS_W'(rnd_h);
                    v_pos <= v_pos + POS_W'(rnd_v);
                end else begin
                    h_pos <= h_pos + POS_W'(h_disp);
                    v_pos <= v_pos + POS_W'(v_disp);
                end
            end else begin
                fld_cnt_q <= fld_cnt_q + 5'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ==== logic/stp_out_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
module stp_out_ctrl
    import stp_pkg::*;
#(
    parameter int OVERLAY_A_SHORT_HALF = OVERLAY_A_SHORT_HALF_CYC,
    parameter int OVERLAY_A_LONG_HALF = OVERLAY_A_LONG_HALF_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic field_start,
    input wire logic black_option_fitted,
    input wire logic [LINE_W-1:0] sig_line_len,
    input wire logic [LINE_W-1:0] blk_line_len,
    input wire logic [3:0] text_rd_idx,
    output logic [POS_W-1:0] scroll_h_pos,
    output logic [POS_W-1:0] scroll_v_pos,
    output logic overlay_a,
    output logic text_show,
    output logic [6:0] text_h_pct,
    output logic [6:0] text_v_pct,
    output logic [7:0] text_char,
    output logic luma_en,
    output logic blue_difference_component_en,
    output logic red_difference_component_en,
    output logic av_sync_measure_mode,
    output logic sig_word_resolution,
    output logic blk_word_resolution,
    output logic sig_edh_en,
    output logic blk_edh_en,
    output logic [1:0] blk_format,
    output logic [1:0] blk_signal_type,
    output logic [HOFS_W-1:0] sig_h_offset,
    output logic [LINE_W-1:0] sig_v_offset,
    output logic [HOFS_W-1:0] blk_h_offset,
    output logic [LINE_W-1:0] blk_v_offset,
    output logic nv_save_logo,
    output logic nv_save_text
);
    logic setup, wr_en;
    logic addr_ok;
    logic [1:0] grp_sel_q;
    logic gi;
    logic [31:0] rd_d;

    logic signed [DISP_W-1:0] h_disp_q, v_disp_q;
    logic [4:0] period_q;
    logic random_q;
    logic overlay_a_en_q, overlay_a_long_q, text_en_q;
    logic [3:0] text_wr_idx_q;
    logic [7:0] text_mem_q [TEXT_LEN];
    logic opt_q;
    logic [31:0] overlay_a_cnt_q;
    logic overlay_a_due_q;

    logic word10_q [2];
    logic edh_q [2];
    logic [HOFS_W-1:0] h_req_q [2];
    logic [LINE_W-1:0] v_req_q [2];
    logic [HOFS_W-1:0] h_step_q [2];
    logic [LINE_W-1:0] v_step_q [2];
    logic [LINE_W-1:0] line_len [2];
    logic [HOFS_W-1:0] h_norm [2];
    logic [LINE_W-1:0] v_norm [2];
    logic norm_busy [2];
    logic [HOFS_W+FRAC_W-1:0] residue;

    assign setup = psel && !penable && !pready;
    assign wr_en = psel && penable && pready && pwrite && addr_ok;
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= ADDR_STATUS);
    assign gi = (grp_sel_q == GRP_BLACK);
    assign line_len[0] = sig_line_len;
    assign line_len[1] = blk_line_len;
    // Fraction of a line turned into clocks of the selected group
    assign residue = (HOFS_W+FRAC_W)'(pwdata[FRAC_W-1:0] * line_len[gi]);

    // Zero-wait slave: setup cycle registers the answer, access cycle shows it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup;
            pslverr <= setup && !addr_ok;
            if (setup) begin
                prdata <= (addr_ok && !pwrite) ? rd_d : 32'h0000_0000;
            end
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        case (paddr)
            ADDR_MOVE: rd_d = {7'h00, v_disp_q, 7'h00, h_disp_q};
            ADDR_MOVE_CFG: rd_d = {23'h0, random_q, 3'h0, period_q};
            ADDR_OVL: rd_d = {9'h0, text_v_pct, 1'b0, text_h_pct, 5'h0, text_en_q,
                              overlay_a_long_q, overlay_a_en_q};
            ADDR_TEXT: rd_d = {20'h0, text_wr_idx_q, text_mem_q[text_wr_idx_q]};
            ADDR_VID: rd_d = {28'h0, av_sync_measure_mode, red_difference_component_en,
                              blue_difference_component_en, luma_en};
            ADDR_BLK: rd_d = {23'h0, opt_q, 2'h0, blk_signal_type, 2'h0, blk_format};
            ADDR_GRP_SEL: rd_d = {30'h0, grp_sel_q};
            ADDR_GRP_VID: rd_d = {30'h0, edh_q[gi], word10_q[gi]};
            ADDR_GRP_HOFS: rd_d = {12'h0, h_norm[gi]};
            ADDR_GRP_VOFS: rd_d = {8'h0, v_norm[gi], 8'h00};
            ADDR_GRP_HSTEP: rd_d = {12'h0, h_step_q[gi]};
            ADDR_GRP_VSTEP: rd_d = {16'h0, v_step_q[gi]};
            ADDR_STATUS: rd_d = {29'h0, norm_busy[1], norm_busy[0], overlay_a};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h_disp_q <= '0;
            v_disp_q <= '0;
            period_q <= RST_PERIOD;
            random_q <= 1'b0;
        end else if (wr_en && paddr == ADDR_MOVE) begin
            h_disp_q <= clamp_disp({{23{pwdata[8]}}, pwdata[8:0]}) & 9'h1fc;
            v_disp_q <= clamp_disp({{23{pwdata[24]}}, pwdata[24:16]});
        end else if (wr_en && paddr == ADDR_MOVE_CFG) begin
            if (pwdata[4:0] < PERIOD_MIN) begin
                period_q <= PERIOD_MIN;
            end else if (pwdata[4:0] > PERIOD_MAX) begin
                period_q <= PERIOD_MAX;
            end else begin
                period_q <= pwdata[4:0];
            end
            random_q <= pwdata[8];
        end
    end

    stp_scroll u_scroll (
        .pclk(pclk),
        .presetn(presetn),
        .field_start(field_start),
        .h_disp(h_disp_q),
        .v_disp(v_disp_q),
        .period(period_q),
        .random_en(random_q),
        .h_pos(scroll_h_pos),
        .v_pos(scroll_v_pos)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overlay_a_en_q <= 1'b0;
            overlay_a_long_q <= 1'b0;
            text_en_q <= 1'b0;
            text_h_pct <= '0;
            text_v_pct <= '0;
        end else if (wr_en && paddr == ADDR_OVL) begin
            overlay_a_en_q <= pwdata[0];
            overlay_a_long_q <= pwdata[1];
            text_en_q <= pwdata[2];
            text_h_pct <= clamp_pct(pwdata[15:8]);
            text_v_pct <= clamp_pct(pwdata[23:16]);
        end
    end

    // Half-interval timer; the toggle itself waits for the next field start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overlay_a_cnt_q <= '0;
            overlay_a_due_q <= 1'b0;
            overlay_a <= 1'b1;
        end else if (!overlay_a_en_q) begin
            overlay_a_cnt_q <= '0;
            overlay_a_due_q <= 1'b0;
            overlay_a <= 1'b1;
        end else begin
            if (overlay_a_due_q && field_start) begin
                overlay_a <= !overlay_a;
                overlay_a_due_q <= 1'b0;
            end else if (overlay_a_cnt_q >= 32'(overlay_a_long_q ? OVERLAY_A_LONG_HALF - 1
                                                        : OVERLAY_A_SHORT_HALF - 1)) begin
                overlay_a_due_q <= 1'b1;
            end
            if (overlay_a_due_q || overlay_a_cnt_q >= 32'(overlay_a_long_q ? OVERLAY_A_LONG_HALF - 1
                                                               : OVERLAY_A_SHORT_HALF - 1)) begin
                overlay_a_cnt_q <= '0;
            end else begin
                overlay_a_cnt_q <= overlay_a_cnt_q + 32'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            text_show <= 1'b0;
        end else begin
            text_show <= text_en_q && overlay_a;
        end
    end

    // Text store has no reset; contents are software defined
    always_ff @(posedge pclk) begin
        if (wr_en && paddr == ADDR_TEXT) begin
            text_mem_q[pwdata[11:8]] <= pwdata[7:0];
        end
        text_char <= text_mem_q[text_rd_idx];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            text_wr_idx_q <= '0;
        end else if (wr_en && paddr == ADDR_TEXT) begin
            text_wr_idx_q <= pwdata[11:8];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {red_difference_component_en, blue_difference_component_en, luma_en} <= RST_COMP_EN;
            av_sync_measure_mode <= 1'b0;
        end else if (wr_en && paddr == ADDR_VID) begin
            luma_en <= pwdata[0];
            blue_difference_component_en <= pwdata[1];
            red_difference_component_en <= pwdata[2];
            av_sync_measure_mode <= pwdata[3];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_q <= 1'b0;
            blk_format <= FMT_525_RATE270;
            blk_signal_type <= SIG_BLACK;
        end else begin
            opt_q <= black_option_fitted;
            if (wr_en && paddr == ADDR_BLK && opt_q) begin
                if (pwdata[1:0] != 2'h3) begin
                    blk_format <= pwdata[1:0];
                end
                blk_signal_type <= pwdata[5:4];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nv_save_logo <= 1'b0;
            nv_save_text <= 1'b0;
        end else begin
            nv_save_logo <= wr_en && paddr == ADDR_CMD && pwdata[0];
            nv_save_text <= wr_en && paddr == ADDR_CMD && pwdata[1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grp_sel_q <= GRP_SIGNAL;
        end else if (wr_en && paddr == ADDR_GRP_SEL &&
                     (pwdata[1:0] == GRP_SIGNAL || pwdata[1:0] == GRP_BLACK)) begin
            grp_sel_q <= pwdata[1:0];
        end
    end

    // Black bank ignores writes while the option is absent
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int g = 0; g < 2; g++) begin
                word10_q[g] <= 1'b1;
                edh_q[g] <= 1'b0;
                h_req_q[g] <= '0;
                v_req_q[g] <= '0;
                h_step_q[g] <= '0;
                v_step_q[g] <= '0;
            end
        end else if (wr_en && (!gi || opt_q)) begin
            case (paddr)
                ADDR_GRP_VID: begin
                    word10_q[gi] <= pwdata[0];
                    edh_q[gi] <= pwdata[1];
                end
                ADDR_GRP_HOFS: h_req_q[gi] <= pwdata[HOFS_W-1:0];
                ADDR_GRP_VOFS: begin
                    v_req_q[gi] <= pwdata[LINE_W+FRAC_W-1:FRAC_W];
                    h_req_q[gi] <= residue[HOFS_W+FRAC_W-1:FRAC_W];
                end
                ADDR_GRP_HSTEP: h_step_q[gi] <= pwdata[HOFS_W-1:0];
                ADDR_GRP_VSTEP: v_step_q[gi] <= pwdata[LINE_W-1:0];
                ADDR_CMD: begin
                    // Down steps stop at zero rather than wrap
                    if (pwdata[4]) begin
                        h_req_q[gi] <= h_req_q[gi] + h_step_q[gi];
                    end else if (pwdata[5]) begin
                        h_req_q[gi] <= (h_req_q[gi] > h_step_q[gi]) ?
                                       h_req_q[gi] - h_step_q[gi] : '0;
                    end
                    if (pwdata[6]) begin
                        v_req_q[gi] <= v_req_q[gi] + v_step_q[gi];
                    end else if (pwdata[7]) begin
                        v_req_q[gi] <= (v_req_q[gi] > v_step_q[gi]) ?
                                       v_req_q[gi] - v_step_q[gi] : '0;
                    end
                end
                default: ;
            endcase
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_norm
        stp_ofs_norm u_norm (
            .pclk(pclk),
            .presetn(presetn),
            .h_req(h_req_q[g]),
            .v_req(v_req_q[g]),
            .line_len(line_len[g]),
            .h_out(h_norm[g]),
            .v_out(v_norm[g]),
            .busy(norm_busy[g])
        );
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sig_word_resolution <= 1'b1;
            blk_word_resolution <= 1'b1;
            sig_edh_en <= 1'b0;
            blk_edh_en <= 1'b0;
            sig_h_offset <= '0;
            sig_v_offset <= '0;
            blk_h_offset <= '0;
            blk_v_offset <= '0;
        end else begin
            sig_word_resolution <= word10_q[0];
            blk_word_resolution <= word10_q[1];
            sig_edh_en <= edh_q[0];
            blk_edh_en <= edh_q[1];
            sig_h_offset <= h_norm[0];
            sig_v_offset <= v_norm[0];
            blk_h_offset <= h_norm[1];
            blk_v_offset <= v_norm[1];
        end
    end
endmodule
`default_nettype wire

// ==== verif/stp_field_src.sv ====
`timescale 1ns/1ns
`default_nettype none
module stp_field_src
    import stp_pkg::*;
#(parameter int FIELD = 64, parameter int LINE = 100) (
    input wire logic pclk, presetn,
    output logic field_start,
    output logic [LINE_W-1:0] sig_line_len, blk_line_len
);
    int cnt;
    // Field reference runs only after reset, so early edges see no field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            field_start <= 1'h0;
        end else begin
            cnt <= (cnt == FIELD - 1) ? 0 : cnt + 1;
            field_start <= (cnt == FIELD - 1);
        end
    end
    assign sig_line_len = LINE_W'(LINE);
    assign blk_line_len = LINE_W'(LINE);
endmodule
`default_nettype wire

// ==== verif/stp_out_ctrl_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module stp_out_ctrl_chk
    import stp_pkg::*;
(
    input wire logic pclk, presetn, psel, penable, pwrite, pready,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic field_start, black_option_fitted, overlay_a, text_show,
    input wire logic [POS_W-1:0] scroll_h_pos, scroll_v_pos,
    input wire logic [6:0] text_h_pct, text_v_pct,
    input wire logic luma_en, blue_difference_component_en,
    input wire logic red_difference_component_en, av_sync_measure_mode,
    input wire logic [1:0] blk_format,
    input wire logic nv_save_logo, nv_save_text
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel & penable & pready;
    sequence s_cmd;
        acc && pwrite && paddr == ADDR_CMD;
    endsequence
    sequence s_vid;
        acc && pwrite && paddr == ADDR_VID;
    endsequence
    property p_save;
        logic [1:0] c;
        (s_cmd, c = pwdata[1:0]) |=> ({nv_save_text, nv_save_logo} == c)
            ##1 (!nv_save_text && !nv_save_logo);
    endproperty
    property p_vid;
        logic [3:0] v;
        (s_vid, v = pwdata[3:0]) |-> ##2 {av_sync_measure_mode,
            red_difference_component_en, blue_difference_component_en, luma_en} == v;
    endproperty
    a_scroll_at_field: assert property (!$stable({scroll_h_pos, scroll_v_pos})
        |-> $past(field_start)) else $error("scroll moved inside a field");
    a_text_gated: assert property (text_show |-> $past(overlay_a))
        else $error("text shown while overlay hidden");
    a_overlay_a_field: assert property ($fell(overlay_a) |-> $past(field_start))
        else $error("overlay hidden off a field boundary");
    a_save_pulse: assert property (p_save)
        else $error("save pulse wrong");
    a_comp_follow: assert property (p_vid)
        else $error("component enables do not follow write");
    a_pct_max: assert property (text_h_pct <= PCT_MAX && text_v_pct <= PCT_MAX)
        else $error("text position above full scale");
    a_fmt_legal: assert property (blk_format != 2'h3)
        else $error("black format illegal");
    a_option_read: assert property (acc && !pwrite && paddr == ADDR_BLK
        |-> prdata[8] == $past(black_option_fitted, 2)) else $error("option bit wrong");
endmodule
bind stp_out_ctrl stp_out_ctrl_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .pready, .paddr, .pwdata, .prdata, .field_start, .black_option_fitted, .overlay_a,
    .text_show, .scroll_h_pos, .scroll_v_pos, .text_h_pct, .text_v_pct, .luma_en,
    .blue_difference_component_en, .red_difference_component_en, .av_sync_measure_mode,
    .blk_format, .nv_save_logo, .nv_save_text);
`default_nettype wire

// ==== verif/sdi_test_pattern_output_control_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module sdi_test_pattern_output_control_tb
    import stp_pkg::*;
;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic fitted = 1'h1, pready, pslverr, ev, o, field_start, overlay_a, text_show;
    logic luma_en, cb, cr, av, sig_res, blk_res, sig_edh, blk_edh, nv_save_logo, nv_save_text;
    logic [7:0] paddr = 8'h00, tc;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic [15:0] sig_line_len, blk_line_len, sig_v_offset, blk_v_offset;
    logic [19:0] sig_h_offset, blk_h_offset;
    logic [11:0] scroll_h_pos, scroll_v_pos, h0, v0;
    logic [6:0] text_h_pct, text_v_pct;
    logic [1:0] blk_format, blk_signal_type;
    int miscompares = 0, tests_run = 0, cycles = 0;
    always #5 pclk = ~pclk;
    stp_field_src #(.FIELD(64), .LINE(100)) u_src (.pclk, .presetn, .field_start,
        .sig_line_len, .blk_line_len);
    // Short overlay_a halves keep the run to under a thousand cycles
    stp_out_ctrl #(.OVERLAY_A_SHORT_HALF(20), .OVERLAY_A_LONG_HALF(40)) dut (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .field_start,
        .black_option_fitted(fitted), .sig_line_len, .blk_line_len, .text_rd_idx(4'h5),
        .scroll_h_pos, .scroll_v_pos, .overlay_a, .text_show, .text_h_pct, .text_v_pct,
        .text_char(tc), .luma_en, .blue_difference_component_en(cb),
        .red_difference_component_en(cr), .av_sync_measure_mode(av),
        .sig_word_resolution(sig_res), .blk_word_resolution(blk_res), .sig_edh_en(sig_edh),
        .blk_edh_en(blk_edh), .blk_format, .blk_signal_type, .sig_h_offset, .sig_v_offset,
        .blk_h_offset, .blk_v_offset, .nv_save_logo, .nv_save_text);
    task report_and_stop;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 10000) begin
            miscompares++;
            report_and_stop;
        end
    end
    task chk(input logic [39:0] g, input logic [39:0] x);
        tests_run++;
        if (g !== x) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    // Idle edge first, so psel never gets two values in one step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rv = prdata;
        ev = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        chk(rv, x);
    endtask
    task fld;
        @(posedge pclk);
        while (field_start !== 1'h1) @(posedge pclk);
    endtask
    task settle;
        do apb(1'h0, ADDR_STATUS, 32'h0); while (rv[2:1] != 2'h0);
    endtask
    task t_regs;
        rdc(ADDR_VID, 32'h7);
        rdc(ADDR_BLK, 32'h101);
        rdc(ADDR_GRP_SEL, 32'h1);
        apb(1'h0, 8'h38, 32'h0);
        chk(ev, 1'h1);
        wr(ADDR_VID, 32'ha);
        wr(ADDR_VID, 32'h5);
        repeat (2) @(posedge pclk);
        chk({av, cr, cb, luma_en}, 4'h5);
        wr(ADDR_TEXT, 32'h541);
        rdc(ADDR_TEXT, 32'h541);
        chk(tc, 8'h41);
        $display("t_regs done");
    endtask
    task t_scroll;
        wr(ADDR_MOVE, 32'h00fd0105);
        rdc(ADDR_MOVE, 32'h00fc0104);
        wr(ADDR_MOVE_CFG, 32'h2);
        fld;
        h0 = scroll_h_pos;
        v0 = scroll_v_pos;
        repeat (4) fld;
        @(posedge pclk);
        chk(scroll_h_pos, 12'(h0 - 12'h1f8));
        chk(scroll_v_pos, v0 + 12'h1f8);
        wr(ADDR_MOVE_CFG, 32'h111);
        rdc(ADDR_MOVE_CFG, 32'h110);
        $display("t_scroll done");
    endtask
    task t_overlay_a;
        wr(ADDR_OVL, 32'h00257f05);
        rdc(ADDR_OVL, 32'h00256405);
        chk({text_h_pct, text_v_pct}, 14'h3225);
        fld;
        fld;
        @(posedge pclk) o = overlay_a;
        fld;
        @(posedge pclk);
        chk(overlay_a, !o);
        wr(ADDR_OVL, 32'h6);
        rdc(ADDR_OVL, 32'h6);
        chk({overlay_a, text_show}, 2'h3);
        wr(ADDR_OVL, 32'h3);
        fld;
        fld;
        chk(text_show, 1'h0);
        $display("t_overlay_a done");
    endtask
    task t_black;
        fitted <= 1'h0;
        wr(ADDR_BLK, 32'h32);
        rdc(ADDR_BLK, 32'h1);
        fitted <= 1'h1;
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_BLK, 32'(i * 17));
            repeat (2) @(posedge pclk);
            chk(blk_format, (i < 3) ? i[1:0] : 2'h2);
            chk(blk_signal_type, i[1:0]);
        end
        wr(ADDR_GRP_VID, 32'h2);
        wr(ADDR_GRP_SEL, 32'h2);
        wr(ADDR_GRP_VID, 32'h1);
        wr(ADDR_GRP_SEL, 32'h3);
        rdc(ADDR_GRP_SEL, 32'h2);
        chk({sig_res, sig_edh, blk_res, blk_edh}, 4'h6);
        $display("t_black done");
    endtask
    task t_ofs;
        wr(ADDR_GRP_SEL, 32'h1);
        wr(ADDR_GRP_HOFS, 32'hfa);
        settle;
        rdc(ADDR_GRP_HOFS, 32'h32);
        chk(sig_v_offset, 16'h2);
        wr(ADDR_GRP_VOFS, 32'h380);
        settle;
        chk({sig_h_offset, sig_v_offset}, 36'h320003);
        wr(ADDR_GRP_HSTEP, 32'h1e);
        wr(ADDR_GRP_VSTEP, 32'h1);
        wr(ADDR_CMD, 32'h90);
        settle;
        chk({sig_h_offset, sig_v_offset}, 36'h500002);
        wr(ADDR_GRP_SEL, 32'h2);
        wr(ADDR_GRP_HOFS, 32'h7);
        settle;
        chk({blk_h_offset, sig_h_offset}, 40'h0000700050);
        wr(ADDR_CMD, 32'h3);
        rdc(ADDR_CMD, 32'h0);
        $display("t_ofs done");
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        t_regs;
        t_scroll;
        t_overlay_a;
        t_black;
        t_ofs;
        report_and_stop;
    end
endmodule
`default_nettype wire
